// ===== cbd_branch_unit.v
// Branch evaluation and delay-slot control for the four conditional branches.
// Assumes the pipeline presents one instruction per valid cycle, in order,
// with its register operands already read.
`default_nettype none
`include "cbd_regs.vh"

// Behaviour
// - target is delay-slot address plus offset times four
// - link variant writes branch address plus eight
// - negative variants test source one sign bit
// - unequal variants branch when sources differ
// - slot executes first, then fetch redirects
// - untaken likely branch annuls the delay slot
// - revision six: slot control transfer raises exception; code flags jump and branch opcodes, not register jumps
// - negative-likely decode: opcode one, subfield two
// - likely variants only before revision six
// - likely branches predicted taken, tables untouched
// - earliest level treats likely negatives as reserved
// - pre-six slot control transfer outcome is free
module cbd_branch_unit #(
    parameter XLEN = 64,
    parameter [2:0] REVISION = 3'h2,
    parameter LEVEL_ONE = 0
) (
    // Clock and reset
    input wire clock_i,
    input wire sys_rst_i,
    // Instruction in
    input wire insn_valid_i,
    input wire [31:0] insn_i,
    input wire [XLEN-1:0] insn_pc_i,
    input wire [XLEN-1:0] source_one_i,
    input wire [XLEN-1:0] source_two_i,
    // Fetch redirect
    output wire redirect_o,
    output reg [XLEN-1:0] redirect_pc_o,
    // Delay slot
    output wire slot_annul_o,
    // Link write to general register file
    output reg link_we_o,
    output reg [4:0] link_sel_o,
    output reg [XLEN-1:0] link_data_o,
    // Exception and prediction
    output reg reserved_insn_o,
    output wire predict_taken_o,
    output wire predictor_bypass_o
);
    // Decoder outputs
    wire neg_link_likely;
    wire neg_likely;
    wire unequal;
    wire unequal_likely;
    wire is_xfer;

    cbd_decode u_decode (
        .insn_i(insn_i),
        .is_neg_link_likely_o(neg_link_likely),
        .is_neg_likely_o(neg_likely),
        .is_unequal_o(unequal),
        .is_unequal_likely_o(unequal_likely),
        .is_xfer_o(is_xfer)
    );

    // Slot tracking: idle, slot of a taken branch, slot of an untaken
    // ordinary branch, slot being annulled
    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_TAKEN = 2'h1;
    localparam [1:0] ST_FALL = 2'h2;
    localparam [1:0] ST_ANNUL = 2'h3;

    wire is_r6;
    wire likely_any;
    wire neg_any;
    wire unequal_any;
    wire likely_ok;
    wire likely_refused;
    wire accept;
    wire in_slot;
    wire slot_bad;
    wire sign_neg;
    wire sources_differ;
    wire [XLEN-1:0] offset_ext;
    wire [XLEN-1:0] slot_pc;
    wire [XLEN-1:0] return_pc;
    wire [XLEN-1:0] branch_target;
    reg cond;
    reg is_branch;
    reg link_we_next;
    reg reserved_next;
    reg [1:0] state_reg;
    reg [1:0] state_next;
    reg [XLEN-1:0] target_reg;
    reg [XLEN-1:0] target_next;

    assign is_r6 = (REVISION >= `CBD_REV_R6);
    assign likely_any = neg_link_likely | neg_likely | unequal_likely;
    assign neg_any = neg_link_likely | neg_likely;
    assign unequal_any = unequal | unequal_likely;
    // Likely forms exist only before revision six and after the first level
    assign likely_ok = !is_r6 && (LEVEL_ONE == 0);
    assign likely_refused = likely_any && !likely_ok;
    assign in_slot = (state_reg != ST_IDLE);
    // A word is judged as a branch only outside a slot
    assign accept = insn_valid_i && !in_slot;

    // Target arithmetic
    assign offset_ext = {{(XLEN-`CBD_TARGET_BITS){insn_i[`CBD_OFF_MSB]}},
                         insn_i[`CBD_OFF_MSB:`CBD_OFF_LSB], 2'b00};
    assign slot_pc = insn_pc_i + `CBD_INSN_BYTES;
    assign return_pc = slot_pc + `CBD_INSN_BYTES;
    assign branch_target = slot_pc + offset_ext;

    // Conditions
    assign sign_neg = source_one_i[XLEN-1];
    assign sources_differ = (source_one_i != source_two_i);

    always @* begin
        cond = 1'b0;
        is_branch = 1'b0;
        if (neg_any) begin
            cond = sign_neg;
            is_branch = likely_ok;
        end else if (unequal_any) begin
            cond = sources_differ;
            is_branch = unequal || likely_ok;
        end
    end

    // Pre-six: a slot control transfer is simply treated as a non-branch
    assign slot_bad = in_slot && is_xfer && is_r6;

    always @* begin
        state_next = state_reg;
        target_next = target_reg;
        case (state_reg)
            ST_IDLE: begin
                if (insn_valid_i && is_branch) begin
                    target_next = branch_target;
                    if (cond) begin
                        state_next = ST_TAKEN;
                    end else if (likely_any) begin
                        state_next = ST_ANNUL;
                    end else begin
                        state_next = ST_FALL;
                    end
                end
            end
            ST_TAKEN: begin
                // Idle cycles hold the state, so the target waits for the slot
                if (insn_valid_i) begin
                    state_next = ST_IDLE;
                end
            end
            ST_FALL: begin
                if (insn_valid_i) begin
                    state_next = ST_IDLE;
                end
            end
            ST_ANNUL: begin
                if (insn_valid_i) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
    end

    always @* begin
        link_we_next = accept && neg_link_likely && likely_ok;
        reserved_next = insn_valid_i && ((likely_refused && !in_slot) || slot_bad);
    end

    // Slot state
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            state_reg <= ST_IDLE;
        end else begin
            state_reg <= state_next;
        end
    end

    // Target and its registered copy toward fetch; fetch reads it only
    // while the redirect pulse stands, so it may follow every branch
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            target_reg <= {XLEN{1'b0}};
            redirect_pc_o <= {XLEN{1'b0}};
        end else begin
            target_reg <= target_next;
            redirect_pc_o <= target_next;
        end
    end

    // Link is written whether or not the branch is taken, so a return
    // address exists even when the call falls through
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            link_we_o <= 1'b0;
            link_sel_o <= 5'h00;
            link_data_o <= {XLEN{1'b0}};
        end else begin
            link_we_o <= link_we_next;
            link_sel_o <= `CBD_LINK_REG;
            link_data_o <= return_pc;
        end
    end

    // Exception flag, one cycle after the offending word
    always @(posedge clock_i) begin
        if (sys_rst_i) begin
            reserved_insn_o <= 1'b0;
        end else begin
            reserved_insn_o <= reserved_next;
        end
    end

    // Redirect fires as the slot instruction retires, never before it
    assign redirect_o = insn_valid_i && (state_reg == ST_TAKEN) && !slot_bad;
    assign slot_annul_o = insn_valid_i && (state_reg == ST_ANNUL);
    // Likely branches always predicted taken and skip the tables; a wrong
    // guess costs a flush, which software accepted by choosing the form
    assign predict_taken_o = accept && likely_any && likely_ok;
    assign predictor_bypass_o = predict_taken_o;
endmodule
`default_nettype wire

// ===== cbd_regs.vh
// Constants for the conditional branch / delay slot unit: opcode fields,
// encodings and layout. Assumes 32-bit instruction words, 64-bit registers.
`ifndef CBD_REGS_VH
`define CBD_REGS_VH

`define CBD_OP_MSB 31
`define CBD_OP_LSB 26
`define CBD_SRC1_MSB 25
`define CBD_SRC1_LSB 21
`define CBD_SRC2_MSB 20
`define CBD_SRC2_LSB 16
`define CBD_OFF_MSB 15
`define CBD_OFF_LSB 0

`define CBD_OP_REG_IMM 6'h01
`define CBD_OP_UNEQUAL 6'h05
`define CBD_OP_UNEQUAL_LIKELY 6'h15
`define CBD_RI_NEG_LIKELY 5'h02
`define CBD_RI_NEG_LINK_LIKELY 5'h12

`define CBD_LINK_REG 5'h1F
`define CBD_INSN_BYTES 64'h0000000000000004
`define CBD_TARGET_BITS 18
`define CBD_REV_R6 3'h6

`endif

// ===== cbd_decode.v
// Instruction classifier for the branch unit: recognises the four branches
// and flags jump and branch opcode words (not register jumps). Purely combinational.
`default_nettype none
`include "cbd_regs.vh"

module cbd_decode (
    // Instruction
    input wire [31:0] insn_i,
    // Classification
    output reg is_neg_link_likely_o,
    output reg is_neg_likely_o,
    output reg is_unequal_o,
    output reg is_unequal_likely_o,
    output reg is_xfer_o
);
    wire [5:0] op;
    wire [4:0] sub;
    assign op = insn_i[`CBD_OP_MSB:`CBD_OP_LSB];
    assign sub = insn_i[`CBD_SRC2_MSB:`CBD_SRC2_LSB];

    always @* begin
        is_neg_link_likely_o = (op == `CBD_OP_REG_IMM) && (sub == `CBD_RI_NEG_LINK_LIKELY);
        is_neg_likely_o = (op == `CBD_OP_REG_IMM) && (sub == `CBD_RI_NEG_LIKELY);
        is_unequal_o = (op == `CBD_OP_UNEQUAL);
        is_unequal_likely_o = (op == `CBD_OP_UNEQUAL_LIKELY);
        // Coarse control-transfer class: register-immediate branches, jumps,
        // and the primary branch opcode range
        is_xfer_o = (op == `CBD_OP_REG_IMM) || (op[5:2] == 4'h0 && op != 6'h00) ||
                    (op[5:2] == 4'h1) || (op[5:2] == 4'h5);
    end
endmodule
`default_nettype wire

// ===== cbd_branch_unit_assertions.sv
// Checker for the branch unit, bound to its ports.
// Assumes one instruction per valid cycle, in order.
`default_nettype none
module cbd_branch_unit_assertions #(parameter XLEN = 64, parameter [2:0] REVISION = 3'h2,
    parameter LEVEL_ONE = 0) (
    input wire logic clock_i, sys_rst_i, insn_valid_i,
    input wire logic [31:0] insn_i,
    input wire logic [XLEN-1:0] insn_pc_i, source_one_i, source_two_i, redirect_pc_o,
    input wire logic [XLEN-1:0] link_data_o,
    input wire logic [4:0] link_sel_o,
    input wire logic redirect_o, slot_annul_o, link_we_o, predict_taken_o, predictor_bypass_o,
    input wire logic reserved_insn_o
);
reg slot_reg, take_reg, lik_reg;
reg [XLEN-1:0] tgt_reg;
wire [5:0] op = insn_i[31:26];
wire lk = op == 6'h15 || op == 6'h01 && (insn_i[20:16] == 5'h02 || insn_i[20:16] == 5'h12);
wire br = insn_valid_i && !slot_reg && (op == 6'h05 || lk && REVISION < 6 && LEVEL_ONE == 0);
wire bl = br && op == 6'h01 && insn_i[20:16] == 5'h12;
wire tk = op[2] ? source_one_i != source_two_i : source_one_i[XLEN-1];
wire [XLEN-1:0] off = {{(XLEN-18){insn_i[15]}}, insn_i[15:0], 2'b00};
wire sl = insn_valid_i && slot_reg;
// Control transfers: register-immediate branches, jumps, primary branch opcodes
wire xf = op == 6'h01 || op == 6'h02 || op == 6'h03 || op[5:2] == 4'h1 || op[5:2] == 4'h5;
always @(posedge clock_i) begin
    // Slot state is only held across valid words, idle cycles keep it
    if (sys_rst_i) slot_reg <= 1'b0;
    else if (insn_valid_i) slot_reg <= br;
    if (insn_valid_i) begin
        take_reg <= tk;
        lik_reg <= lk;
        tgt_reg <= insn_pc_i + 4 + off;
    end
end
default clocking @(posedge clock_i); endclocking
default disable iff (sys_rst_i);
redirect_when_a: assert property (sl && take_reg && !(REVISION >= 6 && xf) |-> redirect_o && redirect_pc_o == tgt_reg)
    else $error("redirect missing or wrong target");
redirect_only_a: assert property (redirect_o |-> sl && take_reg)
    else $error("redirect without taken branch");
annul_when_a: assert property (sl && lik_reg && !take_reg |-> slot_annul_o)
    else $error("slot not annulled");
annul_only_a: assert property (slot_annul_o |-> sl && lik_reg && !take_reg)
    else $error("slot annulled wrongly");
link_write_a: assert property (bl |=> link_we_o && link_sel_o == 5'h1F && link_data_o == $past(insn_pc_i) + 8)
    else $error("link write wrong");
link_only_a: assert property (link_we_o |-> $past(bl))
    else $error("link write without cause");
predict_a: assert property (predict_taken_o == (br && lk) && predictor_bypass_o == (br && lk))
    else $error("prediction flags wrong");
target_hold_a: assert property (slot_reg && !insn_valid_i |=> $stable(redirect_pc_o))
    else $error("target moved while waiting");
slot_transfer_a: assert property (REVISION >= 6 && sl && xf |-> !redirect_o ##1 reserved_insn_o)
    else $error("slot transfer not refused");
likely_refused_a: assert property (insn_valid_i && !slot_reg && lk && !(REVISION < 6 && LEVEL_ONE == 0) |=> reserved_insn_o)
    else $error("refused likely branch not flagged");
cover property (sl && take_reg);
cover property (slot_annul_o);
cover property (link_we_o);
endmodule
bind cbd_branch_unit cbd_branch_unit_assertions #(.XLEN(XLEN), .REVISION(REVISION),
    .LEVEL_ONE(LEVEL_ONE)) u_chk (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .insn_valid_i(insn_valid_i), .insn_i(insn_i), .insn_pc_i(insn_pc_i),
    .source_one_i(source_one_i), .source_two_i(source_two_i), .redirect_pc_o(redirect_pc_o),
    .link_data_o(link_data_o), .link_sel_o(link_sel_o), .redirect_o(redirect_o),
    .slot_annul_o(slot_annul_o), .link_we_o(link_we_o), .predict_taken_o(predict_taken_o),
    .predictor_bypass_o(predictor_bypass_o), .reserved_insn_o(reserved_insn_o));
`default_nettype wire

// ===== cbd_branch_unit_tb_top.sv
// Self-checking bench for the branch unit: branch word, then its slot.
// Assumes nothing else is attached; a second copy is built as revision six.
`default_nettype none
module cbd_branch_unit_tb_top;
timeunit 1ns;
timeprecision 1ps;
logic clock_i, sys_rst_i, v, redirect_o, slot_annul_o, link_we_o, reserved_insn_o, pt, pb;
logic [31:0] ins;
logic [63:0] pc, s1, s2, redirect_pc_o, link_data_o;
logic [4:0] link_sel_o;
logic r6_redirect, r6_annul, r6_link_we, r6_reserved, r6_pt, r6_pb;
int err_count, checks;
cbd_branch_unit dut (.clock_i(clock_i), .sys_rst_i(sys_rst_i), .insn_valid_i(v), .insn_i(ins),
    .insn_pc_i(pc), .source_one_i(s1), .source_two_i(s2), .redirect_o(redirect_o),
    .redirect_pc_o(redirect_pc_o), .slot_annul_o(slot_annul_o), .link_we_o(link_we_o),
    .link_sel_o(link_sel_o), .link_data_o(link_data_o), .reserved_insn_o(reserved_insn_o),
    .predict_taken_o(pt), .predictor_bypass_o(pb));
cbd_branch_unit #(.REVISION(3'h6)) dut_r6 (.clock_i(clock_i), .sys_rst_i(sys_rst_i),
    .insn_valid_i(v), .insn_i(ins), .insn_pc_i(pc), .source_one_i(s1), .source_two_i(s2),
    .redirect_o(r6_redirect), .redirect_pc_o(), .slot_annul_o(r6_annul),
    .link_we_o(r6_link_we), .link_sel_o(), .link_data_o(), .reserved_insn_o(r6_reserved),
    .predict_taken_o(r6_pt), .predictor_bypass_o(r6_pb));
initial begin
    clock_i = 1'b0;
    forever #5 clock_i = ~clock_i;
end
task automatic chk(input string n, input logic [63:0] e, input logic [63:0] g);
    checks++;
    if (g !== e) begin
        err_count++;
        $display("ERROR %s expected %h seen %h", n, e, g);
    end
endtask
task automatic step(input logic vv, input logic [31:0] i, input logic [63:0] p, a, b);
    @(negedge clock_i);
    v = vv;
    ins = i;
    pc = p;
    s1 = a;
    s2 = b;
    #1;
endtask
// Sources are registers 1 to 3, never the link register; slot is a plain word
task automatic run(input string n, input logic [31:0] i, input logic [63:0] a, b,
    input int gap, input logic er, ea, el, ep);
    step(1'b1, i, 64'h1000, a, b);
    chk("predict", {62'h0, ep, ep}, {62'h0, pt, pb});
    repeat (gap) step(1'b0, 32'h0, 64'h0, 64'h0, 64'h0);
    step(1'b1, 32'h0, 64'h1004, 64'h0, 64'h0);
    chk("redirect", {63'h0, er}, {63'h0, redirect_o});
    chk("annul", {63'h0, ea}, {63'h0, slot_annul_o});
    chk("reserved", 64'h0, {63'h0, reserved_insn_o});
    if (er) chk("target", 64'h1004 + {{46{i[15]}}, i[15:0], 2'b00}, redirect_pc_o);
    if (gap == 0) chk("link_we", {63'h0, el}, {63'h0, link_we_o});
    if (el) chk("link_data", 64'h1008, link_data_o);
    if (el) chk("link_sel", 64'h1F, {59'h0, link_sel_o});
    step(1'b0, 32'h0, 64'h0, 64'h0, 64'h0);
    $display("done %s", n);
endtask
task automatic t_ne_taken; run("ne taken", {16'h1422, 16'hFFFE}, 5, 6, 0, 1, 0, 0, 0); endtask
task automatic t_ne_same; run("ne same", {16'h1422, 16'h0003}, 5, 5, 0, 0, 0, 0, 0); endtask
task automatic t_nel_same; run("nel same", {16'h5422, 16'h0003}, 7, 7, 0, 0, 1, 0, 1); endtask
task automatic t_link;
    run("link neg", {16'h0472, 16'h0010}, 64'h8000000000000000, 0, 0, 1, 0, 1, 1);
endtask
task automatic t_neg_pos;
    run("neg pos", {16'h0462, 16'h7FFF}, 64'h7FFFFFFFFFFFFFFF, 0, 0, 0, 1, 0, 1);
endtask
// A branch in the slot of a branch: refused by revision six, ignored before it
task automatic t_slot_xfer;
    step(1'b1, {16'h1422, 16'h0004}, 64'h2000, 64'h1, 64'h2);
    step(1'b1, {16'h1422, 16'h0004}, 64'h2004, 64'h1, 64'h2);
    chk("r6 redirect", 64'h0, {63'h0, r6_redirect});
    chk("redirect", 64'h1, {63'h0, redirect_o});
    step(1'b0, 32'h0, 64'h0, 64'h0, 64'h0);
    chk("r6 reserved", 64'h1, {63'h0, r6_reserved});
    chk("reserved", 64'h0, {63'h0, reserved_insn_o});
    $display("done slot transfer");
endtask
// Likely form on revision six: refused, no prediction, no slot handling
task automatic t_r6_likely;
    step(1'b1, {16'h5422, 16'h0004}, 64'h3000, 64'h1, 64'h2);
    chk("r6 predict", 64'h0, {62'h0, r6_pt, r6_pb});
    step(1'b1, 32'h0, 64'h3004, 64'h0, 64'h0);
    chk("r6 reserved", 64'h1, {63'h0, r6_reserved});
    chk("r6 redirect", 64'h0, {63'h0, r6_redirect});
    chk("r6 annul", 64'h0, {63'h0, r6_annul});
    chk("r6 link_we", 64'h0, {63'h0, r6_link_we});
    chk("redirect", 64'h1, {63'h0, redirect_o});
    step(1'b0, 32'h0, 64'h0, 64'h0, 64'h0);
    $display("done revision six likely");
endtask
task automatic t_gap; run("gap", {16'h5422, 16'h8000}, 1, 2, 2, 1, 0, 0, 1); endtask
task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
endtask
initial begin
    {v, ins, pc, s1, s2, err_count, checks} = '0;
    sys_rst_i = 1'b1;
    repeat (20) @(posedge clock_i);
    @(negedge clock_i);
    sys_rst_i = 1'b0;
    t_ne_taken();
    t_ne_same();
    t_nel_same();
    t_link();
    t_neg_pos();
    t_gap();
    t_slot_xfer();
    t_r6_likely();
    wrap_up();
end
endmodule
`default_nettype wire
